// ===== rtl/stm_params.svh
// Register map, field positions, reset values and period shift of the timer
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define STM_ADDR_CTL_A 12'h000
`define STM_ADDR_CTL_B 12'h004
`define STM_ADDR_CNT_LO 12'h008
`define STM_ADDR_CNT_HI 12'h00c
`define STM_ADDR_CMP_LO 12'h010
`define STM_ADDR_CMP_HI 12'h014
`define STM_ADDR_FLAGS 12'h018
// ----------------------------------------
// Field positions, control A
// ----------------------------------------
`define STM_A_PAUSE 7
`define STM_A_CLK_HI 6
`define STM_A_CLK_LO 4
`define STM_A_ON 3
`define STM_A_PER_HI 2
`define STM_A_PER_LO 0
// ----------------------------------------
// Field positions, control B
// ----------------------------------------
`define STM_B_MODE_HI 7
`define STM_B_MODE_LO 6
`define STM_B_FUNC_HI 5
`define STM_B_FUNC_LO 4
`define STM_B_INIT 3
`define STM_B_POL 2
`define STM_B_SWAP 1
`define STM_B_CSEL 0
// ----------------------------------------
// Flag bits and reset values
// ----------------------------------------
`define STM_F_MATCH_A 0
`define STM_F_MATCH_P 1
`define STM_CTL_RST 8'h00
`define STM_CNT_RST 10'h000
`define STM_PER_SHIFT 7
`endif

// ===== rtl/stm_pkg.sv
// Types shared by the standard timer
package stm_pkg;
   // Operating modes in the order of their field codes
   typedef enum logic [1:0] {
      STM_MODE_CMP,
      STM_MODE_CAP,
      STM_MODE_PWM,
      STM_MODE_TMR
   } stm_mode_e;
   // Clock source codes
   typedef logic [2:0] stm_clk_t;
endpackage

// ===== rtl/stm_timer.sv
// Standard 10-bit timer with APB register slave
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "stm_params.svh"
module stm_timer
   import stm_pkg::*;
(
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic clk_en, // Freezes all state when low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic timebase_clock, // Time-base tick, one pclk pulse
   input wire logic ext_clock_pin, // External count pin
   input wire logic capture_pin, // Capture input pin
   output logic timer_out_pin, // Compare/PWM output level
   output logic timer_out_oe // High while the timer drives the pin
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0] ctl_a_q; // Control register A
   logic [7:0] ctl_b_q; // Control register B
   logic [9:0] cnt_q; // Main counter
   logic [9:0] cmp_a_q; // Compare A value
   logic [7:0] cnt_buf_q; // Counter low-byte buffer
   logic [7:0] cmp_buf_q; // Compare low-byte buffer
   logic [1:0] flags_q; // Sticky match flags
   logic on_dly_q; // Delayed on bit for edge detect
   logic [5:0] pre_q; // Prescaler
   logic [2:0] ext_sync_q; // External clock sync and history
   logic [2:0] cap_sync_q; // Capture pin sync and history
   logic out_lvl_q; // Compare-mode output level
   logic pulse_q; // Single pulse still active
   logic [31:0] prdata_q; // Read data register
   logic pready_q; // Ready register
   logic pslverr_q; // Error register
   logic pin_q; // Output pin register
   logic oe_q; // Output enable register

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   wire pause_ctl = ctl_a_q[`STM_A_PAUSE]; // Pause control
   wire stm_clk_t clk_select = ctl_a_q[`STM_A_CLK_HI:`STM_A_CLK_LO]; // Clock source
   wire timer_on_ctl = ctl_a_q[`STM_A_ON]; // On/off control
   wire [2:0] period_setting = ctl_a_q[`STM_A_PER_HI:`STM_A_PER_LO]; // P value
   wire stm_mode_e op_mode_field = stm_mode_e'(ctl_b_q[`STM_B_MODE_HI:`STM_B_MODE_LO]);
   wire [1:0] out_func_field = ctl_b_q[`STM_B_FUNC_HI:`STM_B_FUNC_LO]; // Output function
   wire out_init_level = ctl_b_q[`STM_B_INIT]; // Initial or active level
   wire out_polarity = ctl_b_q[`STM_B_POL]; // Pin inversion
   wire period_duty_swap = ctl_b_q[`STM_B_SWAP]; // Period/duty roles
   wire clear_select = ctl_b_q[`STM_B_CSEL]; // Counter clear source

   // Mode shortcuts
   wire mode_cmp = (op_mode_field == STM_MODE_CMP);
   wire mode_cap = (op_mode_field == STM_MODE_CAP);
   wire mode_pwm = (op_mode_field == STM_MODE_PWM);
   wire mode_tmr = (op_mode_field == STM_MODE_TMR);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // True when a count value reaches the period setting times 128
   function automatic logic p_hit(input logic [9:0] v, input logic [2:0] p);
      p_hit = (v[9:7] == p) && (v[6:0] == 7'h00);
   endfunction

   // True when the count lies below the period setting times 128, or when the period setting is zero
   function automatic logic p_below(input logic [9:0] v, input logic [2:0] p);
      p_below = (p == 3'h0) || (v < {p, 7'h00});
   endfunction

   // ----------------------------------------
   // Tick generation
   // ----------------------------------------
   // Pin edges come from the second and third stages, never the first
   wire ext_rise = ext_sync_q[1] & ~ext_sync_q[2];
   wire ext_fall = ~ext_sync_q[1] & ext_sync_q[2];
   wire cap_rise = cap_sync_q[1] & ~cap_sync_q[2];
   wire cap_fall = ~cap_sync_q[1] & cap_sync_q[2];

   logic tick_src; // Selected tick
   always_comb begin
      unique case (clk_select)
         3'h0: tick_src = (pre_q[1:0] == 2'h3);
         3'h1: tick_src = 1'b1;
         3'h2: tick_src = (pre_q[3:0] == 4'hf);
         3'h3: tick_src = (pre_q == 6'h3f);
         3'h4: tick_src = timebase_clock;
         3'h5: tick_src = (pre_q[2:0] == 3'h7);
         3'h6: tick_src = ext_rise;
         3'h7: tick_src = ext_fall;
      endcase
   end

   // Counting only while switched on and not paused
   wire on_rise = timer_on_ctl & ~on_dly_q;
   wire tick = tick_src & timer_on_ctl & ~pause_ctl & ~on_rise;

   // ----------------------------------------
   // Comparators
   // ----------------------------------------
   wire [9:0] cnt_nxt = cnt_q + 10'h001; // Next count
   wire hit_a = tick & (cnt_nxt == cmp_a_q);
   wire hit_p = tick & p_hit(cnt_nxt, period_setting);

   // Clear source per mode; PWM period follows the swap bit
   wire clr_cm = clear_select ? hit_a : hit_p;
   wire clr_pwm = period_duty_swap ? hit_a : hit_p;
   wire clr_any = mode_pwm ? clr_pwm : (mode_cap ? hit_p : clr_cm);

   // P flag is never raised when A clears the counter in compare modes
   wire flag_p_set = hit_p & ~((mode_cmp | mode_tmr) & clear_select);
   wire flag_a_cm = hit_a & ~mode_cap; // A flag from comparator

   // Capture edge selection
   logic cap_evt; // Capture event
   always_comb begin
      unique case (out_func_field)
         2'h0: cap_evt = cap_rise;
         2'h1: cap_evt = cap_fall;
         2'h2: cap_evt = cap_rise | cap_fall;
         2'h3: cap_evt = 1'b0;
      endcase
   end
   wire cap_take = mode_cap & timer_on_ctl & cap_evt; // Capture strobe
   wire flag_a_set = flag_a_cm | cap_take; // A flag sources

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   wire setup = psel & ~penable; // Setup cycle
   wire access = psel & penable & pready_q; // Completing access
   wire wr = access & pwrite; // Write takes effect
   wire rd = access & ~pwrite; // Read completes
   wire sel_ca = (paddr == `STM_ADDR_CTL_A);
   wire sel_cb = (paddr == `STM_ADDR_CTL_B);
   wire sel_dl = (paddr == `STM_ADDR_CNT_LO);
   wire sel_dh = (paddr == `STM_ADDR_CNT_HI);
   wire sel_al = (paddr == `STM_ADDR_CMP_LO);
   wire sel_ah = (paddr == `STM_ADDR_CMP_HI);
   wire sel_fl = (paddr == `STM_ADDR_FLAGS);
   wire mapped = sel_ca | sel_cb | sel_dl | sel_dh | sel_al | sel_ah | sel_fl;

   // Read mux; low bytes come from the buffers, high reads show live bits
   wire [7:0] rd_byte = sel_ca ? ctl_a_q :
                        sel_cb ? ctl_b_q :
                        sel_dl ? cnt_buf_q :
                        sel_dh ? {6'h00, cnt_q[9:8]} :
                        sel_al ? cmp_buf_q :
                        sel_ah ? {6'h00, cmp_a_q[9:8]} :
                        sel_fl ? {6'h00, flags_q} : 8'h00;

   // ----------------------------------------
   // Output function
   // ----------------------------------------
   // PWM duty: the non-period comparator sets the active span
   wire duty_on = period_duty_swap ? p_below(cnt_q, period_setting)
                                   : (cnt_q < cmp_a_q);
   logic pwm_lvl; // Active-high PWM/pulse request
   always_comb begin
      unique case (out_func_field)
         2'h0: pwm_lvl = 1'b0;
         2'h1: pwm_lvl = 1'b1;
         2'h2: pwm_lvl = duty_on;
         2'h3: pwm_lvl = pulse_q;
      endcase
   end
   // Active level chosen by the init bit
   wire pwm_pin = pwm_lvl ? out_init_level : ~out_init_level;
   wire raw_pin = mode_pwm ? pwm_pin : out_lvl_q; // Level before inversion
   wire pin_d = (raw_pin ^ out_polarity) & ~mode_tmr;
   // Pin released in timer and capture modes or while off
   wire oe_d = timer_on_ctl & (mode_cmp | mode_pwm);

   // Compare-mode level after a comparator A match
   logic lvl_d; // Next compare-mode level
   always_comb begin
      lvl_d = out_lvl_q;
      if (on_rise) begin
         lvl_d = out_init_level;
      end else if (mode_cmp && hit_a) begin
         unique case (out_func_field)
            2'h0: lvl_d = out_lvl_q;
            2'h1: lvl_d = 1'b0;
            2'h2: lvl_d = 1'b1;
            2'h3: lvl_d = ~out_lvl_q;
         endcase
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   // Software writes steer the whole block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_a_q <= `STM_CTL_RST;
         ctl_b_q <= `STM_CTL_RST;
      end else if (clk_en) begin
         if (wr && sel_ca) begin
            ctl_a_q <= pwdata[7:0];
         end
         if (wr && sel_cb) begin
            ctl_b_q <= pwdata[7:0];
         end
      end
   end

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   // No software load path; the on-bit rise or the mode's clear match zeroes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= `STM_CNT_RST;
         on_dly_q <= 1'b0;
      end else if (clk_en) begin
         on_dly_q <= timer_on_ctl;
         if (on_rise) begin
            cnt_q <= `STM_CNT_RST;
         end else if (clr_any) begin
            cnt_q <= `STM_CNT_RST;
         end else if (tick) begin
            cnt_q <= cnt_nxt;
         end
      end
   end

   // ----------------------------------------
   // Compare value and byte buffers
   // ----------------------------------------
   // Low byte is staged; a high-byte write commits both halves at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_a_q <= `STM_CNT_RST;
         cmp_buf_q <= 8'h00;
         cnt_buf_q <= 8'h00;
      end else if (clk_en) begin
         if (wr && sel_al) begin
            cmp_buf_q <= pwdata[7:0];
         end else if (rd && sel_ah) begin
            cmp_buf_q <= cmp_a_q[7:0];
         end
         if (cap_take) begin
            cmp_a_q <= cnt_q;
         end else if (wr && sel_ah) begin
            cmp_a_q <= {pwdata[1:0], cmp_buf_q};
         end
         if (rd && sel_dh) begin
            cnt_buf_q <= cnt_q[7:0];
         end
      end
   end

   // ----------------------------------------
   // Match flags
   // ----------------------------------------
   // Write one to clear; a match in the same cycle wins over the clear
   wire [1:0] flag_set = {flag_p_set, flag_a_set};
   wire [1:0] flag_clr = (wr && sel_fl) ? pwdata[1:0] : 2'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= 2'h0;
      end else if (clk_en) begin
         flags_q <= (flags_q & ~flag_clr) | flag_set;
      end
   end

   // ----------------------------------------
   // Prescaler and synchronisers
   // ----------------------------------------
   // Prescaler runs free so divided ticks keep phase across restarts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 6'h00;
         ext_sync_q <= 3'h0;
         cap_sync_q <= 3'h0;
      end else if (clk_en) begin
         pre_q <= pre_q + 6'h01;
         ext_sync_q <= {ext_sync_q[1:0], ext_clock_pin};
         cap_sync_q <= {cap_sync_q[1:0], capture_pin};
      end
   end

   // ----------------------------------------
   // Output stage
   // ----------------------------------------
   // Pulse starts at switch-on and ends at the duty comparator match
   wire pulse_end = period_duty_swap ? hit_p : hit_a;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_lvl_q <= 1'b0;
         pulse_q <= 1'b0;
         pin_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (clk_en) begin
         out_lvl_q <= lvl_d;
         if (on_rise) begin
            pulse_q <= 1'b1;
         end else if (pulse_end || !timer_on_ctl) begin
            pulse_q <= 1'b0;
         end
         pin_q <= pin_d;
         oe_q <= oe_d;
      end
   end

   // ----------------------------------------
   // APB response
   // ----------------------------------------
   // Ready rises for the access phase only, so every transfer is one wait-free access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (clk_en) begin
         pready_q <= setup;
         pslverr_q <= setup & ~mapped;
         if (setup && !pwrite) begin
            prdata_q <= {24'h00_0000, rd_byte};
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign timer_out_pin = pin_q;
   assign timer_out_oe = oe_q;

endmodule // stm_timer

// ===== tb/standard_timer_10bit_bench.sv
// Self-checking bench for the standard timer
`timescale 1ns/100ps
`include "stm_params.svh"
module standard_timer_10bit_bench import stm_pkg::*;;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rv;
   logic pready, pslverr, timer_out_pin, timer_out_oe, ext_clock_pin, capture_pin, re;
   logic clk_en = 1'b1; // Freeze control, dropped only between transfers
   logic timebase_clock = 1'b0; // Time-base tick, one pclk pulse
   int error_cnt = 0, n_checks = 0;
   // Rows: control B value, expected pin, expected enable
   logic [9:0] rows [13] = '{10'h023, 10'h061, 10'h083, 10'h0c3, 10'h091, 10'h221,
      10'h263, 10'h271, 10'h2a1, 10'h2ab, 10'h2e1, 10'h2eb, 10'h300};
   always #4 pclk = ~pclk;
   // Clock enable and time-base tick come from the bench so both get exercised
   stm_timer i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timebase_clock(timebase_clock),
      .ext_clock_pin(ext_clock_pin), .capture_pin(capture_pin),
      .timer_out_pin(timer_out_pin), .timer_out_oe(timer_out_oe));
   stm_pins_model i_pins (.pclk(pclk), .ext_clock_pin(ext_clock_pin),
      .capture_pin(capture_pin));
   task automatic summarize();
      if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; waits for ready, takes the answer at that edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int t;
      t = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      // A transfer that never completes counts against the run
      if (pready !== 1'b1) error_cnt++;
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Time-base ticks, each one pclk wide
   task automatic tb_ticks(input int n);
      repeat (n) begin
         @(posedge pclk);
         timebase_clock <= 1'b1;
         @(posedge pclk);
         timebase_clock <= 1'b0;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 8'h00);
      chk(rv, exp);
   endtask
   // High part first, so the low byte comes through the buffer
   task automatic pair(input logic [11:0] hi, input logic [9:0] v);
      rc(hi, {30'h0, v[9:8]});
      rc(hi - 12'h004, {24'h0, v[7:0]});
   endtask
   initial begin
      repeat (40000) @(posedge pclk);
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 7; i++) rc(12'(i * 4), 32'h0);
      wr(`STM_ADDR_CTL_B, 8'hc0);
      wr(`STM_ADDR_CTL_A, 8'h68);
      i_pins.pulse(5);
      pair(`STM_ADDR_CNT_HI, 10'd5);
      wr(`STM_ADDR_CTL_A, 8'he8);
      i_pins.pulse(3);
      pair(`STM_ADDR_CNT_HI, 10'd5);
      wr(`STM_ADDR_CTL_A, 8'h68);
      i_pins.pulse(2);
      pair(`STM_ADDR_CNT_HI, 10'd7);
      wr(`STM_ADDR_CTL_A, 8'h60);
      i_pins.pulse(2);
      pair(`STM_ADDR_CNT_HI, 10'd7);
      wr(`STM_ADDR_CTL_A, 8'h68);
      pair(`STM_ADDR_CNT_HI, 10'd0);
      wr(`STM_ADDR_CTL_A, 8'h78);
      i_pins.pulse(3);
      pair(`STM_ADDR_CNT_HI, 10'd3);
      wr(`STM_ADDR_CTL_A, 8'h60);
      wr(`STM_ADDR_FLAGS, 8'h03);
      wr(`STM_ADDR_CTL_A, 8'h79);
      i_pins.pulse(130);
      pair(`STM_ADDR_CNT_HI, 10'd2);
      rc(`STM_ADDR_FLAGS, 32'h2);
      wr(`STM_ADDR_CTL_A, 8'h61);
      wr(`STM_ADDR_CMP_LO, 8'hc8);
      wr(`STM_ADDR_CMP_HI, 8'h00);
      wr(`STM_ADDR_CTL_B, 8'hc1);
      wr(`STM_ADDR_FLAGS, 8'h03);
      wr(`STM_ADDR_CTL_A, 8'h69);
      i_pins.pulse(203);
      pair(`STM_ADDR_CNT_HI, 10'd3);
      rc(`STM_ADDR_FLAGS, 32'h1);
      wr(`STM_ADDR_CMP_LO, 8'h55);
      pair(`STM_ADDR_CMP_HI, 10'h0c8);
      wr(`STM_ADDR_CMP_LO, 8'h03);
      wr(`STM_ADDR_CMP_HI, 8'h00);
      foreach (rows[i]) begin
         wr(`STM_ADDR_CTL_A, 8'h60);
         wr(`STM_ADDR_CTL_B, rows[i][9:2]);
         wr(`STM_ADDR_CTL_A, 8'h68);
         i_pins.pulse(3);
         chk(timer_out_pin, rows[i][1]);
         chk(timer_out_oe, rows[i][0]);
      end
      wr(`STM_ADDR_CTL_A, 8'h60);
      wr(`STM_ADDR_CTL_B, 8'h40);
      wr(`STM_ADDR_CTL_A, 8'h68);
      i_pins.pulse(4);
      i_pins.cap_flip();
      pair(`STM_ADDR_CMP_HI, 10'd4);
      wr(`STM_ADDR_CTL_B, 8'h50);
      i_pins.pulse(2);
      i_pins.cap_flip();
      pair(`STM_ADDR_CMP_HI, 10'd6);
      wr(`STM_ADDR_CTL_B, 8'h70);
      i_pins.pulse(1);
      i_pins.cap_flip();
      pair(`STM_ADDR_CMP_HI, 10'd6);
      wr(`STM_ADDR_CTL_B, 8'h60);
      i_pins.pulse(1);
      i_pins.cap_flip();
      pair(`STM_ADDR_CMP_HI, 10'd8);
      i_pins.pulse(1);
      i_pins.cap_flip();
      pair(`STM_ADDR_CMP_HI, 10'd9);
      // Time-base source, then a clock-enable freeze that must hold the count
      wr(`STM_ADDR_CTL_A, 8'h60);
      wr(`STM_ADDR_CTL_B, 8'hc0);
      wr(`STM_ADDR_CTL_A, 8'h48);
      tb_ticks(5);
      @(posedge pclk);
      clk_en <= 1'b0;
      tb_ticks(3);
      @(posedge pclk);
      clk_en <= 1'b1;
      pair(`STM_ADDR_CNT_HI, 10'd5);
      wr(12'h01c, 8'hff);
      chk(re, 1'b1);
      rc(12'h020, 32'h0);
      chk(re, 1'b1);
      // Reset again in mid-run: everything returns to zero
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rc(`STM_ADDR_CTL_B, 32'h0);
      pair(`STM_ADDR_CNT_HI, 10'd0);
      summarize();
   end
endmodule // standard_timer_10bit_bench

// ===== tb/stm_pins_model.sv
// Pin-side partner: drives the external count pin and the capture pin
`timescale 1ns/100ps
module stm_pins_model (
   input wire logic pclk, // System clock
   output logic ext_clock_pin, // Count pin, low between bursts
   output logic capture_pin // Capture pin
);
   initial begin
      ext_clock_pin = 1'b0;
      capture_pin = 1'b0;
   end
   // Each level lasts 4 cycles so the three-flop sampler never misses one
   task automatic pulse(input int n);
      repeat (n) begin
         repeat (4) @(posedge pclk);
         ext_clock_pin <= 1'b1;
         repeat (4) @(posedge pclk);
         ext_clock_pin <= 1'b0;
      end
      // Let the synchroniser and pin register settle
      repeat (6) @(posedge pclk);
   endtask
   // One capture edge, direction alternates with each call
   task automatic cap_flip();
      @(posedge pclk);
      capture_pin <= ~capture_pin;
      repeat (6) @(posedge pclk);
   endtask
endmodule // stm_pins_model

// ===== tb/stm_timer_asserts.sv
// Port-level checker for the standard timer
`timescale 1ns/100ps
`include "stm_params.svh"
module stm_timer_asserts import stm_pkg::*; (
   input wire logic pclk, // System clock
   input wire logic presetn, // Reset, active low
   input wire logic clk_en, // Clock enable
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic timebase_clock, // Time-base tick
   input wire logic ext_clock_pin, // Count pin
   input wire logic capture_pin, // Capture pin
   input wire logic timer_out_pin, // Output level
   input wire logic timer_out_oe // Output enable
);
   logic [7:0] ca_q; // Shadow of control A, taken from bus writes
   logic [7:0] cb_q; // Shadow of control B
   wire wr_acc = psel && penable && pready && pwrite && clk_en;
   // Mode and the on bit decide whether the pin is driven at all
   wire oe_exp = ca_q[3] && (cb_q[7:6] == STM_MODE_CMP || cb_q[7:6] == STM_MODE_PWM);
   // Shadows update on the same edge as the real registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ca_q <= 8'h00;
         cb_q <= 8'h00;
      end else if (wr_acc && paddr == `STM_ADDR_CTL_A) begin
         ca_q <= pwdata[7:0];
      end else if (wr_acc && paddr == `STM_ADDR_CTL_B) begin
         cb_q <= pwdata[7:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable && clk_en;
   endsequence
   sequence s_on_rise;
      $rose(ca_q[3]) && cb_q[7:6] == STM_MODE_CMP;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> pready)
      else $error("no ready after setup");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_err_unmapped: assert property (s_setup ##0 paddr > `STM_ADDR_FLAGS |=> pslverr)
      else $error("unmapped address not refused");
   a_err_mapped: assert property (
      s_setup ##0 paddr <= `STM_ADDR_FLAGS && paddr[1:0] == 2'b00 |=> !pslverr)
      else $error("mapped address refused");
   a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_ctl_readback: assert property (
      s_setup ##0 !pwrite && paddr == `STM_ADDR_CTL_A |=> prdata[7:0] == ca_q)
      else $error("control A reads back wrong");
   a_oe_follows: assert property (timer_out_oe == $past(oe_exp))
      else $error("output enable wrong for mode");
   a_init_level: assert property (
      s_on_rise |-> ##[2:3] timer_out_pin == (cb_q[3] ^ cb_q[2]))
      else $error("pin not at initial level");
   a_pin_tmr: assert property (
      $past(cb_q[7:6]) == STM_MODE_TMR && cb_q[7:6] == STM_MODE_TMR |-> !timer_out_pin)
      else $error("pin driven in timer mode");
   a_pwm_forced: assert property (
      cb_q[7:5] == 3'b100 && $stable(cb_q) && ca_q[3] && $past(ca_q[3])
      |-> timer_out_pin == (cb_q[3] ^ cb_q[2] ^ !cb_q[4]))
      else $error("forced level wrong");
endmodule // stm_timer_asserts
bind stm_timer stm_timer_asserts i_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .timebase_clock(timebase_clock),
   .ext_clock_pin(ext_clock_pin), .capture_pin(capture_pin),
   .timer_out_pin(timer_out_pin), .timer_out_oe(timer_out_oe));
